/* File: design/sms_core.sv */
// Serial shift unit: master engine, slave link logic and flags
`include "sms_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sms_core (
  // Bus clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Control bits and software accesses
  input wire sms_pkg::sms_ctrl_s i_ctrl,
  input wire logic i_ctrl_wr,
  input wire logic i_status_rd,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_rd,
  // Software view
  output sms_pkg::sms_status_s o_status,
  output logic [7:0] o_rx_data,
  output logic o_tx_irq,
  output logic o_rx_err_irq,
  // Serial clock pin, also the slave link clock
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe,
  // Data and select pins
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_slave_select_b
);

  sms_pkg::sms_core_s r_r;
  sms_pkg::sms_core_s r_nxt;

  // Link domain state
  logic [2:0] lk_bit_cnt_r;
  logic [2:0] lk_out_idx_r;
  logic [7:0] lk_rx_sh_r;
  logic [7:0] lk_rx_hold_r;
  logic lk_toggle_r;
  logic link_clk;
  logic link_clr;
  logic link_rst;

  // Synchronised pin and link levels
  logic [`SMS_SYNC_W-1:0] sync_in;
  logic [`SMS_SYNC_W-1:0] sync_out;
  logic ss_s;
  logic miso_s;
  logic tog_s;
  logic busy_s;

  // Combinational helpers
  logic master;
  logic slave;
  logic [4:0] half_lim;
  logic edge_now;
  logic sample_edge;
  logic byte_done;
  logic [7:0] byte_val;
  logic mode_fault_flag_cond;

  assign sync_in = {i_slave_select_b, i_miso, lk_toggle_r, (lk_bit_cnt_r != 3'h0)};

  sms_sync #(
    .WIDTH(`SMS_SYNC_W),
    .RESET_VAL(4'h8)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign ss_s = sync_out[3];
  assign miso_s = sync_out[2];
  assign tog_s = sync_out[1];
  assign busy_s = sync_out[0];

  // Link clock: inverted where needed so that sampling is always the rising edge
  assign link_clk = i_serial_clock_pin ^ r_r.link_inv; // RL9
  // A high select ends the frame even without further clock edges
  assign link_clr = i_slave_select_b | ~i_rst_b; // RL19
  assign link_rst = ~i_rst_b;

  // Slave shift-in on the sampling edge; counters die with the frame
  always_ff @(posedge link_clk or posedge link_clr) begin
    if (link_clr) begin
      lk_bit_cnt_r <= 3'h0;
      lk_rx_sh_r <= `SMS_DATA_RST;
    end else if (r_r.link_en) begin
      lk_rx_sh_r <= {lk_rx_sh_r[6:0], i_mosi}; // RL25
      lk_bit_cnt_r <= lk_bit_cnt_r + 3'h1;
    end
  end

  // Completed byte is held and announced by a toggle; survives the frame end
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      lk_rx_hold_r <= `SMS_DATA_RST;
      lk_toggle_r <= 1'b0;
    end else if (r_r.link_en && !i_slave_select_b && lk_bit_cnt_r == `SMS_LAST_BIT) begin
      lk_rx_hold_r <= {lk_rx_sh_r[6:0], i_mosi}; // RL11
      lk_toggle_r <= ~lk_toggle_r;
    end
  end

  // Output bit index moves on the shifting edge, half a period after sampling
  always_ff @(negedge link_clk or posedge link_clr) begin
    if (link_clr) begin
      lk_out_idx_r <= 3'h0;
    end else begin
      lk_out_idx_r <= lk_bit_cnt_r;
    end
  end

  // Rate divider lookup
  always_comb begin
    case ({i_ctrl.rate_select_hi, i_ctrl.rate_select_lo})
      2'b00: half_lim = `SMS_HALF_RATE0; // RL4
      2'b01: half_lim = `SMS_HALF_RATE1;
      2'b10: half_lim = `SMS_HALF_RATE2;
      default: half_lim = `SMS_HALF_RATE3;
    endcase
  end

  // Role and mode fault condition
  always_comb begin
    master = i_ctrl.module_enable & i_ctrl.master_select; // RL1
    slave = i_ctrl.module_enable & ~i_ctrl.master_select; // RL1
    // Master sees select pulled low; slave sees select rise inside a byte
    mode_fault_flag_cond = (master & ~ss_s) | (slave & ss_s & ~r_r.ss_seen & r_r.busy_seen);
  end

  // Next state of the bus clock domain
  always_comb begin
    r_nxt = r_r;
    edge_now = 1'b0;
    sample_edge = 1'b0;
    byte_done = 1'b0;
    byte_val = r_r.shift;
    r_nxt.ss_seen = ss_s;
    r_nxt.busy_seen = busy_s;
    r_nxt.sck_oe = master; // RL9
    r_nxt.mosi_oe = master;
    r_nxt.miso_oe = slave & ~ss_s; // RL19
    r_nxt.link_en = slave;
    r_nxt.link_inv = i_ctrl.clk_polarity ^ i_ctrl.clk_phase; // RL25

    // Status read arms the clearing sequences
    if (i_status_rd) begin
      r_nxt.rx_armed = r_r.status.rx_full_flag; // RL7
      r_nxt.ovf_armed = r_r.status.overflow_flag;
      r_nxt.mode_fault_flag_armed = r_r.status.mode_fault_flag; // RL20
    end

    // Clears come first so that a set in the same cycle wins
    if (i_data_rd && r_r.rx_armed) begin
      r_nxt.status.rx_full_flag = 1'b0; // RL7
      r_nxt.rx_armed = 1'b0;
      if (r_r.ovf_armed) begin
        r_nxt.status.overflow_flag = 1'b0;
        r_nxt.ovf_armed = 1'b0;
      end
    end
    if (i_ctrl_wr) begin
      r_nxt.mode_fault_flag_armed = 1'b0;
      if (r_r.mode_fault_flag_armed && !mode_fault_flag_cond) begin
        r_nxt.status.mode_fault_flag = 1'b0; // RL20
      end
    end

    // Writes land in the transmit buffer
    if (i_data_wr) begin
      r_nxt.tx_buf = i_data_wdata;
      r_nxt.buf_full = 1'b1;
      r_nxt.status.tx_empty_flag = 1'b0; // RL8
    end

    // Master engine
    case (r_r.state)
      sms_pkg::SMS_IDLE: begin
        r_nxt.sck = i_ctrl.clk_polarity;
        r_nxt.half_cnt = 5'h00;
        r_nxt.edge_cnt = 5'h00;
        // Only a master starts, and only with a byte in the buffer
        if (master && r_r.buf_full && !i_data_wr) begin
          r_nxt.shift = r_r.tx_buf; // RL2
          r_nxt.buf_full = 1'b0;
          r_nxt.status.tx_empty_flag = 1'b1; // RL3
          r_nxt.state = sms_pkg::SMS_XFER; // RL13
        end
      end
      sms_pkg::SMS_XFER: begin
        if (!master) begin
          // Software dropped the enable or role: abandon the byte
          r_nxt.state = sms_pkg::SMS_IDLE;
        end else if (r_r.half_cnt == half_lim - 5'h01) begin
          r_nxt.half_cnt = 5'h00;
          r_nxt.sck = ~r_r.sck;
          r_nxt.edge_cnt = r_r.edge_cnt + 5'h01;
          edge_now = 1'b1;
        end else begin
          r_nxt.half_cnt = r_r.half_cnt + 5'h01;
        end
        if (edge_now) begin
          sample_edge = (r_r.edge_cnt[0] == i_ctrl.clk_phase);
          if (r_r.edge_cnt == `SMS_LAST_EDGE) begin
            // Last edge: full byte gathered
            byte_done = 1'b1;
            byte_val = {r_r.shift[6:0], i_ctrl.clk_phase ? miso_s : r_r.rx_bit}; // RL5
            r_nxt.state = sms_pkg::SMS_IDLE;
          end else if (sample_edge) begin
            r_nxt.rx_bit = miso_s; // RL5
          end else if (!(i_ctrl.clk_phase && r_r.edge_cnt == 5'h00)) begin
            r_nxt.shift = {r_r.shift[6:0], r_r.rx_bit}; // RL25
          end
        end
      end
      default: begin
        r_nxt.state = sms_pkg::SMS_IDLE;
      end
    endcase

    // Slave byte arrives from the link domain as a toggle
    if (tog_s != r_r.toggle_seen) begin
      r_nxt.toggle_seen = tog_s;
      if (slave) begin
        byte_done = 1'b1;
        byte_val = lk_rx_hold_r; // RL11
      end
    end

    // End of byte: capture or overflow, then refill the shifter
    if (byte_done) begin
      if (r_nxt.status.rx_full_flag) begin
        r_nxt.status.overflow_flag = 1'b1; // RL24
      end else begin
        r_nxt.rx_data = byte_val; // RL6
        r_nxt.status.rx_full_flag = 1'b1; // RL6
      end
      // Without a new byte the received value goes out next time
      r_nxt.shift = byte_val; // RL15
      if (slave && r_r.buf_full && !i_data_wr) begin
        r_nxt.shift = r_r.tx_buf; // RL17
        r_nxt.buf_full = 1'b0;
        r_nxt.status.tx_empty_flag = 1'b1;
      end
    end else if (slave && ss_s && r_r.buf_full && !i_data_wr) begin
      // Idle slave loads at once; a busy one waits for the byte end
      r_nxt.shift = r_r.tx_buf; // RL17
      r_nxt.buf_full = 1'b0;
      r_nxt.status.tx_empty_flag = 1'b1; // RL16
    end

    if (mode_fault_flag_cond) begin
      r_nxt.status.mode_fault_flag = 1'b1; // RL18
    end

    // Requests follow the flags as they will stand next cycle
    r_nxt.tx_irq = r_nxt.status.tx_empty_flag & i_ctrl.tx_irq_enable
                   & i_ctrl.module_enable; // RL22
    r_nxt.rx_irq = (r_nxt.status.rx_full_flag & i_ctrl.rx_irq_enable) // RL23
                   | ((r_nxt.status.overflow_flag | r_nxt.status.mode_fault_flag)
                      & i_ctrl.error_irq_enable); // RL18 RL24
  end

  // Bus domain register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      r_r <= '0;
      r_r.state <= sms_pkg::SMS_IDLE;
      r_r.tx_buf <= `SMS_DATA_RST;
      r_r.shift <= `SMS_DATA_RST;
      r_r.rx_data <= `SMS_DATA_RST;
      r_r.status.tx_empty_flag <= 1'b1;
      r_r.ss_seen <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs; slave MISO picks a bit of the stable shift register
  assign o_status = r_r.status;
  assign o_rx_data = r_r.rx_data;
  assign o_tx_irq = r_r.tx_irq;
  assign o_rx_err_irq = r_r.rx_irq;
  assign o_serial_clock_pin = r_r.sck; // RL4
  assign o_serial_clock_pin_oe = r_r.sck_oe;
  assign o_mosi = r_r.shift[7]; // RL25
  assign o_mosi_oe = r_r.mosi_oe;
  assign o_miso = r_r.shift[3'h7 - lk_out_idx_r];
  assign o_miso_oe = r_r.miso_oe; // RL19

endmodule

`default_nettype wire

/* File: design/sms_defs.svh */
// Constants for the serial shift unit: widths, rates, reset values
//
// Behaviour
// (RL1) Master while master_select set, else slave
// (RL2) Only master starts; data write starts it
// (RL3) Write to empty shifter loads, sets tx_empty
// (RL4) Rate select sets master serial clock speed
// (RL5) Master shifts in while shifting out
// (RL6) Byte done: rx_full set, data captured
// (RL7) rx_full clears: status read, data read
// (RL8) Data register write clears tx_empty
// (RL9) Slave takes serial clock pin as input
// (RL10) Master holds select low whole transfer
// (RL11) Slave byte complete: capture, set rx_full
// (RL12) Slave software reads data before next byte
// (RL13) Master sends queued byte right after previous
// (RL14) Software writes data only when tx_empty
// (RL15) No new byte: resend shift register contents
// (RL16) Idle: tx_empty sets within two cycles
// (RL17) Busy slave loads buffer only after byte
// (RL18) Slave mode fault raises error request
// (RL19) Select high: MISO released, clocks ignored
// (RL20) Mode fault clears: status read, control write
// (RL21) Configure roles before enable; order enables
// (RL22) tx_empty request needs enable and module on
// (RL23) rx_full request needs only its enable
// (RL24) Overflow raises error request when enabled
// (RL25) Eight bits, MSB first, configurable phase
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

`define SMS_BYTE_W 8
`define SMS_CNT_W 5
// Half serial clock periods in bus cycles for rate select 0..3
`define SMS_HALF_RATE0 5'h01
`define SMS_HALF_RATE1 5'h04
`define SMS_HALF_RATE2 5'h08
`define SMS_HALF_RATE3 5'h10
// Serial clock edges per byte, index of the last one
`define SMS_LAST_EDGE 5'h0f
`define SMS_LAST_BIT 3'h7
`define SMS_DATA_RST 8'h00
`define SMS_SYNC_W 4

`endif

/* File: design/sms_pkg.sv */
// Types shared by the serial shift unit
package sms_pkg;

  typedef enum logic {
    SMS_IDLE,
    SMS_XFER
  } sms_state_e;

  typedef struct packed {
    logic module_enable;
    logic master_select;
    logic clk_polarity;
    logic clk_phase;
    logic rate_select_hi;
    logic rate_select_lo;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic error_irq_enable;
  } sms_ctrl_s;

  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic overflow_flag;
    logic mode_fault_flag;
  } sms_status_s;

  typedef struct packed {
    sms_state_e state;
    logic [4:0] half_cnt;
    logic [4:0] edge_cnt;
    logic [7:0] tx_buf;
    logic buf_full;
    logic [7:0] shift;
    logic rx_bit;
    logic [7:0] rx_data;
    sms_status_s status;
    logic rx_armed;
    logic ovf_armed;
    logic mode_fault_flag_armed;
    logic sck;
    logic sck_oe;
    logic mosi_oe;
    logic miso_oe;
    logic link_en;
    logic link_inv;
    logic toggle_seen;
    logic busy_seen;
    logic ss_seen;
    logic tx_irq;
    logic rx_irq;
  } sms_core_s;

endpackage

/* File: design/sms_sync.sv */
// Two-flop synchroniser for levels entering the bus clock domain
`timescale 1ns/100ps
`default_nettype none

module sms_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("sms_sync needs at least one bit");
  end

  // First stage feeds only the second stage
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta_r <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* File: sim/sms_core_chk.sv */
// Port checker for the serial shift unit, bound to its core
`timescale 1ns/100ps
`default_nettype none

module sms_core_chk (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Software side
  input wire sms_pkg::sms_ctrl_s i_ctrl,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire sms_pkg::sms_status_s o_status,
  input wire logic [7:0] o_rx_data,
  input wire logic o_tx_irq,
  input wire logic o_rx_err_irq,
  // Pins
  input wire logic o_serial_clock_pin,
  input wire logic o_serial_clock_pin_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe,
  input wire logic i_slave_select_b
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // Requests follow flags; enables are registered, so compare with last cycle
  a_tx_irq_gate: assert property (o_tx_irq |-> o_status.tx_empty_flag && $past(i_ctrl.module_enable))
    else $error("tx request without flag or enable");
  a_rx_irq_set: assert property (o_status.rx_full_flag && $past(i_ctrl.rx_irq_enable) |-> o_rx_err_irq)
    else $error("rx request missing");
  a_err_irq_set: assert property ((o_status.overflow_flag || o_status.mode_fault_flag) && $past(i_ctrl.error_irq_enable) |-> o_rx_err_irq)
    else $error("error request missing");
  // Flag set and clear relations
  a_wr_clears_empty: assert property (i_data_wr |=> !o_status.tx_empty_flag)
    else $error("write left tx empty set");
  a_rx_full_holds: assert property (o_status.rx_full_flag && !i_data_rd |=> o_status.rx_full_flag)
    else $error("rx full cleared without data read");
  a_rx_data_hold: assert property ($changed(o_rx_data) |-> o_status.rx_full_flag)
    else $error("rx data moved without rx full");
  // Pin drive by role and select; master serial clock half period at rate select 1
  a_slave_no_drive: assert property (!$past(i_ctrl.master_select) |-> !o_serial_clock_pin_oe && !o_mosi_oe)
    else $error("slave drives clock or mosi");
  a_miso_released: assert property (i_slave_select_b [*4] |=> !o_miso_oe)
    else $error("miso driven while deselected");
  a_rate_one_half: assert property ($changed(o_serial_clock_pin) && i_ctrl.master_select && !i_ctrl.rate_select_hi && i_ctrl.rate_select_lo |=> $stable(o_serial_clock_pin) [*3])
    else $error("serial clock half period too short");

  // Main scenarios
  c_rx_full: cover property ($rose(o_status.rx_full_flag));
  c_overflow: cover property ($rose(o_status.overflow_flag));
  c_mode_fault: cover property ($rose(o_status.mode_fault_flag));
endmodule

bind sms_core sms_core_chk u_chk (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ctrl(i_ctrl),
  .i_data_wr(i_data_wr), .i_data_rd(i_data_rd), .o_status(o_status), .o_rx_data(o_rx_data),
  .o_tx_irq(o_tx_irq), .o_rx_err_irq(o_rx_err_irq), .o_serial_clock_pin(o_serial_clock_pin),
  .o_serial_clock_pin_oe(o_serial_clock_pin_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe),
  .i_slave_select_b(i_slave_select_b));

`default_nettype wire

/* File: sim/sms_core_tb.sv */
// Self-checking bench for the serial shift unit with a far-side peer
`timescale 1ns/100ps
`default_nettype none

module sms_core_tb;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  sms_pkg::sms_ctrl_s ctrl = '0;
  logic [3:0] req = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic pm = 1'b0;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  logic [7:0] half [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
  sms_pkg::sms_status_s st;
  logic [7:0] rxd;
  logic tx_irq, err_irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic p_sck, p_mosi, p_miso, p_miso_oe, p_sel_b, sck_w, mosi_w, miso_w, sel_w;
  logic [4:0] obs;

  // Bus clock 25 MHz
  always #20 i_clock = ~i_clock;
  // Wire levels; an undriven data line toggles every half cycle
  assign sck_w = sck_oe ? sck_o : p_sck;
  assign mosi_w = mosi_oe ? mosi_o : (pm ? p_mosi : i_clock);
  assign miso_w = miso_oe ? miso_o : (p_miso_oe ? p_miso : i_clock);
  assign sel_w = pm ? p_sel_b : 1'b1;
  assign obs = {st, sck_o};

  sms_core dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ctrl(ctrl), .i_ctrl_wr(req[3]),
    .i_status_rd(req[2]), .i_data_wr(req[1]), .i_data_wdata(wdata), .i_data_rd(req[0]),
    .o_status(st), .o_rx_data(rxd), .o_tx_irq(tx_irq), .o_rx_err_irq(err_irq),
    .i_serial_clock_pin(sck_w), .o_serial_clock_pin(sck_o), .o_serial_clock_pin_oe(sck_oe),
    .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe), .i_miso(miso_w), .o_miso(miso_o),
    .o_miso_oe(miso_oe), .i_slave_select_b(sel_w));
  sms_peer peer (.i_is_master(pm), .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w),
    .o_sck(p_sck), .o_mosi(p_mosi), .o_miso(p_miso), .o_miso_oe(p_miso_oe),
    .o_select_b(p_sel_b));

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask
  // One software access pulse {ctrl_wr, status_rd, data_wr, data_rd}, then a gap
  task automatic sw(input logic [3:0] k, input logic [7:0] d);
    req = k;
    wdata = d;
    tick();
    req = 4'h0;
    tick();
  endtask
  task automatic rdclr();
    sw(4'h4, 8'h00);
    sw(4'h1, 8'h00);
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for one observed bit to reach a level; n counts the cycles
  task automatic wt(input int b, input logic v);
    n = 0;
    while (obs[b] !== v && n < 3000) begin
      tick();
      n++;
    end
    if (n == 3000) begin
      num_errors++;
      stop_test();
    end
  endtask
  // Data write while idle: empty flag drops, then is checked back set three cycles after the write
  task automatic wr_chk(input logic [7:0] d);
    logic s0;
    s0 = 1'b0;
    req = 4'h2;
    wdata = d;
    tick();
    req = 4'h0;
    repeat (3) begin
      s0 |= !st.tx_empty_flag;
      tick();
    end
    chk("tx_empty fell", 8'(s0), 8'h01);
    chk("tx_empty back", 8'(st.tx_empty_flag), 8'h01);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    #1;
    chk("reset pins", {st, tx_irq, err_irq, sck_oe, mosi_oe}, 8'h80);
    chk("reset rx_data", rxd, 8'h00);
    i_rst_b = 1'b1;
    tick();
    ctrl = 9'h08f;
    tick();
    tick();
    chk("tx_irq off", 8'(tx_irq), 8'h00);
    ctrl.module_enable = 1'b1;
    tick();
    tick();
    chk("tx_irq on", 8'(tx_irq), 8'h01);
    $display("test reset and requests done");
    // Master byte at rate selects 1 to 3; a lone data read must not clear
    for (int r = 1; r < 4; r++) begin
      {ctrl.rate_select_hi, ctrl.rate_select_lo} = 2'(r);
      peer.tx_r = 8'(8'h30 + r);
      wr_chk(8'(8'ha0 + r));
      wt(0, 1'b1);
      wt(0, 1'b0);
      chk("half period", 8'(n), half[r]);
      wt(3, 1'b1);
      chk("master rx", rxd, 8'(8'h30 + r));
      chk("peer rx", peer.rx_r, 8'(8'ha0 + r));
      chk("rx request", 8'(err_irq), 8'h01);
      sw(4'h1, 8'h00);
      chk("rx_full kept", 8'(st.rx_full_flag), 8'h01);
      rdclr();
      chk("rx_full cleared", 8'(st.rx_full_flag), 8'h00);
      $display("test master rate %0d done", r);
    end
    // Queued second byte, left unread so it overflows
    ctrl = 9'h18f;
    peer.tx_r = 8'h96;
    wr_chk(8'h81);
    sw(4'h2, 8'h7e);
    wt(2, 1'b1);
    chk("kept on overflow", rxd, 8'h96);
    chk("queued byte", peer.rx_r, 8'h7e);
    chk("error request", 8'(err_irq), 8'h01);
    rdclr();
    chk("flags cleared", 8'(st), 8'h08);
    $display("test queue and overflow done");
    // Slave role: disable, change role, enable
    ctrl.module_enable = 1'b0;
    tick();
    ctrl.master_select = 1'b0;
    pm = 1'b1;
    tick();
    ctrl.module_enable = 1'b1;
    tick();
    wr_chk(8'hc3);
    peer.xfer(8'h5a, 16);
    wt(3, 1'b1);
    chk("slave rx", rxd, 8'h5a);
    chk("slave tx", peer.rx_r, 8'hc3);
    rdclr();
    peer.xfer(8'h69, 16);
    wt(3, 1'b1);
    chk("resend", peer.rx_r, 8'h5a);
    rdclr();
    $display("test slave done");
    // Frame aborted by select, then mode fault clearing
    peer.xfer(8'h00, 6);
    wt(1, 1'b1);
    chk("fault request", 8'(err_irq), 8'h01);
    sw(4'h8, 8'h00);
    chk("fault kept", 8'(st.mode_fault_flag), 8'h01);
    sw(4'h4, 8'h00);
    sw(4'h8, 8'h00);
    chk("fault cleared", 8'(st.mode_fault_flag), 8'h00);
    peer.xfer(8'he1, 16);
    wt(3, 1'b1);
    chk("after abort", rxd, 8'he1);
    $display("test mode fault done");
    stop_test();
  end
endmodule

`default_nettype wire

/* File: sim/sms_peer.sv */
// Far-side serial peer: slave while the unit is master, master otherwise
`timescale 1ns/100ps
`default_nettype none

module sms_peer (
  // Role
  input wire logic i_is_master,
  // Board lines
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_select_b
);
  logic [7:0] tx_r = 8'h00;
  logic [7:0] rx_r = 8'h00;

  initial begin
    o_sck = 1'b0;
    o_select_b = 1'b1;
  end
  // Sample on rising, shift on falling, MSB first; each frame resends the inverse
  always @(posedge i_sck) rx_r <= {rx_r[6:0], i_is_master ? i_miso : i_mosi};
  always @(negedge i_sck) tx_r = {tx_r[6:0], ~tx_r[7]};
  // Mosi shows garbage while deselected
  assign o_mosi = tx_r[7] ^ o_select_b;
  assign o_miso = tx_r[7];
  assign o_miso_oe = !i_is_master;

  // Master frame; the link clock runs only inside it, 30 ns period
  task automatic xfer(input logic [7:0] b, input int e);
    tx_r = b;
    o_select_b = 1'b0;
    #150;
    repeat (e) begin
      o_sck = ~o_sck;
      #15;
    end
    #150;
    o_sck = 1'b0;
    o_select_b = 1'b1;
  endtask
endmodule

`default_nettype wire
